// ---- common/codec_defs.svh ----
`ifndef CODEC_DEFS_SVH
`define CODEC_DEFS_SVH
// register word addresses
`define A_MEAS_IN 8'h00
`define A_MEAS_OUT 8'h01
`define A_METER_HI 8'h02
`define A_METER_LO 8'h03
`define A_METER_STAT 8'h04
`define A_TAP_CMD 8'h05
`define A_TAP_POS 8'h06
`define A_TIME_STAT 8'h07
`define A_EV_CFG 8'h08
`define A_EV_STAT 8'h09
`define A_EV_WIN 5'h02
// field positions and reset values
`define CFG_CAUSE_EN 0
`define CFG_RST 16'h0001
`define GS_BIT 7
`define SCAN_LAST_ENTRY_FLAG_BIT 6
// value codes
`define MEAS_BAD 16'h8000
`define METER_WRAP 32'h7fffffff
`define METER_SETTLE 2'h2
`define TAP_LOWER 16'h0001
`define TAP_RAISE 16'h0002
`define TAP_MAX 6'h3e
`define TAP_BAD 6'h3f
`define TAP_UNROUTED 16'h8000
`define TS_DST 8'h10
`define TS_FAIL 8'h20
`define TS_INVALID 8'h40
`define TYPE_COIL 8'h00
`define TYPE_DISC 8'h01
`define TYPE_HOLD 8'h04
`define TYPE_EMPTY 8'hff
`define INFO_SINGLE 4'h1
`define INFO_DOUBLE 4'h2
`define INFO_TAP 4'h3
`define INFO_STAT 4'h4
`define YEAR_BASE 12'h76c
`define CAUSE_SPONTANEOUS 3'h0
`define CAUSE_INTERMEDIATE 3'h1
`define CAUSE_COMMAND_ISSUED 3'h2
`define CAUSE_LOCAL_ABORT 3'h3
`define CAUSE_COMMAND_REJECTED 3'h4
`define CAUSE_FEEDBACK_NEGATIVE 3'h5
`define CAUSE_FEEDBACK_POSITIVE 3'h6
// event store geometry
`define EV_SLOTS 3'h4
`define EV_LAST_WORD 3'h7
`define RAM_WORDS 32
`endif

// ---- common/codec_pkg.sv ----
package codec_pkg;
  typedef enum logic [1:0] {KIND_COIL, KIND_DISCRETE, KIND_HOLDING} reg_kind_e;
  typedef enum logic [1:0] {INFO_SINGLE, INFO_DOUBLE, INFO_TAP, INFO_STAT} info_kind_e;
  typedef enum logic {PACK_IDLE, PACK_WRITE} pack_state_e;
endpackage

// ---- hw/event_slot_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "codec_defs.svh"
module event_slot_ram (
  // clock
  input wire logic sys_clk_i,
  // write port
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [15:0] wdata_i,
  // read port, data one cycle later
  input wire logic [4:0] raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem_q [0:`RAM_WORDS-1];

  // no reset: the top masks slots that hold no entry
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule
`default_nettype wire

// ---- hw/register_value_codec.sv ----
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "codec_defs.svh"
module register_value_codec (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // measured value
  input wire logic [15:0] meas_raw_i,
  input wire logic meas_invalid_i,
  output logic [15:0] meas_out_o,
  // metered count
  input wire logic meter_inc_i,
  input wire logic meter_update_i,
  input wire logic meter_err_i,
  // tap changer
  output logic tap_lower_o,
  output logic tap_raise_o,
  output logic tap_reject_o,
  input wire logic [5:0] tap_pos_i,
  input wire logic tap_invalid_i,
  input wire logic tap_unassigned_i,
  // clock status
  input wire logic dst_i,
  input wire logic time_fail_i,
  input wire logic time_invalid_i,
  // event entry
  input wire logic ev_valid_i,
  output logic ev_ready_o,
  input wire logic [1:0] ev_reg_kind_i,
  input wire logic [15:0] ev_mask_i,
  input wire logic [16:0] ev_reg_num_i,
  input wire logic [2:0] ev_cause_i,
  input wire logic [1:0] ev_info_kind_i,
  input wire logic ev_gscan_i,
  input wire logic ev_scan_last_entry_flag_i,
  input wire logic [15:0] ev_value_i,
  input wire logic [15:0] ev_ms_i,
  input wire logic [4:0] ev_hour_i,
  input wire logic [5:0] ev_min_i,
  input wire logic [3:0] ev_month_i,
  input wire logic [4:0] ev_day_i,
  input wire logic [11:0] ev_year_i,
  output logic [2:0] ev_count_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic [15:0] meas_q, meas_out_q, snap_q, tap_q, cfg_q, rd_q, rd_d;
  logic [31:0] count_q;
  logic [1:0] settle_q, tap_res_q, wr_slot_q, rd_slot_q;
  logic [7:0] time_q;
  logic tap_lower_q, tap_raise_q, tap_reject_q, win_q, empty_q, idx0_q;
  logic [2:0] cnt_q, idx_q;
  logic [7:0][15:0] words_q;
  codec_pkg::pack_state_e state_q;

  // register strobes
  wire wr_meas_out = wr_i && (addr_i == `A_MEAS_OUT);
  wire wr_tap = wr_i && (addr_i == `A_TAP_CMD);
  wire wr_cfg = wr_i && (addr_i == `A_EV_CFG);
  wire wr_release = wr_i && (addr_i == `A_EV_STAT);
  wire rd_hi = rd_i && (addr_i == `A_METER_HI);
  wire win_hit = (addr_i[7:3] == `A_EV_WIN);

  // measured value
  wire [15:0] meas_d = meas_invalid_i ? `MEAS_BAD : meas_raw_i;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      meas_q <= 16'h0000;
      meas_out_q <= 16'h0000;
    end else begin
      meas_q <= meas_d;
      // plain value, 8000 hex is just the most negative number here
      if (wr_meas_out) meas_out_q <= wdata_i;
    end
  end
  assign meas_out_o = meas_out_q;

  // metered count
  wire [31:0] count_d = (count_q == `METER_WRAP) ? 32'h00000000 : count_q + 32'h00000001;
  wire startup = (settle_q != `METER_SETTLE);
  wire meter_stat = startup || meter_err_i;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      count_q <= 32'h00000000;
      settle_q <= 2'h0;
      snap_q <= 16'h0000;
    end else begin
      if (meter_inc_i) count_q <= count_d;
      if (meter_update_i && startup) settle_q <= settle_q + 2'h1;
      // low half frozen by the high read, so a pair never tears
      if (rd_hi) snap_q <= count_q[15:0];
    end
  end

  // tap change command
  wire tap_is_lower = (wdata_i == `TAP_LOWER);
  wire tap_is_raise = (wdata_i == `TAP_RAISE);
  wire tap_bad = !tap_is_lower && !tap_is_raise;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tap_lower_q <= 1'b0;
      tap_raise_q <= 1'b0;
      tap_reject_q <= 1'b0;
      tap_res_q <= 2'h0;
    end else begin
      tap_lower_q <= wr_tap && tap_is_lower;
      tap_raise_q <= wr_tap && tap_is_raise;
      tap_reject_q <= wr_tap && tap_bad;
      if (wr_tap) tap_res_q <= {tap_bad, !tap_bad};
    end
  end
  assign tap_lower_o = tap_lower_q;
  assign tap_raise_o = tap_raise_q;
  assign tap_reject_o = tap_reject_q;

  // tap position; 0 or above 62 from the inputs is also invalid
  wire tap_out_range = tap_invalid_i || (tap_pos_i == 6'h00) || (tap_pos_i > `TAP_MAX);
  wire [5:0] tap_val = tap_out_range ? `TAP_BAD : tap_pos_i;
  wire [15:0] tap_d = tap_unassigned_i ? `TAP_UNROUTED : {10'h000, tap_val};

  // time status byte
  wire [7:0] time_d = (dst_i ? `TS_DST : 8'h00) | (time_fail_i ? `TS_FAIL : 8'h00)
                      | (time_invalid_i ? `TS_INVALID : 8'h00);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tap_q <= `TAP_UNROUTED;
      time_q <= 8'h00;
      cfg_q <= `CFG_RST;
    end else begin
      tap_q <= tap_d;
      time_q <= time_d;
      if (wr_cfg) cfg_q <= wdata_i;
    end
  end

  // event entry fields
  wire cause_en = cfg_q[`CFG_CAUSE_EN];
  wire cause_actual = (ev_cause_i == `CAUSE_SPONTANEOUS) || (ev_cause_i == `CAUSE_INTERMEDIATE)
                      || (ev_cause_i == `CAUSE_FEEDBACK_POSITIVE);
  wire ev_full = (cnt_q == `EV_SLOTS);
  wire pack_idle = (state_q == codec_pkg::PACK_IDLE);
  assign ev_ready_o = pack_idle && !ev_full;
  wire ev_take = ev_valid_i && ev_ready_o;
  // events dropped by the cause filter are still consumed
  wire start_pack = ev_take && (cause_en || cause_actual);

  logic [3:0] off_acc [0:16];
  assign off_acc[0] = 4'h0;
  for (genvar g = 0; g < 16; g++) begin : g_off
    assign off_acc[g+1] = off_acc[g] | (ev_mask_i[g] ? 4'(g) : 4'h0);
  end

  codec_pkg::reg_kind_e kind;
  codec_pkg::info_kind_e info;
  assign kind = codec_pkg::reg_kind_e'(ev_reg_kind_i);
  assign info = codec_pkg::info_kind_e'(ev_info_kind_i);
  wire is_hold = (kind == codec_pkg::KIND_HOLDING);
  wire [7:0] type_b = (kind == codec_pkg::KIND_COIL) ? `TYPE_COIL :
                      (kind == codec_pkg::KIND_DISCRETE) ? `TYPE_DISC : `TYPE_HOLD;
  wire [7:0] off_b = is_hold ? {4'h0, off_acc[16]} : 8'h00;
  wire [16:0] reg_addr = ev_reg_num_i - 17'h00001;
  wire [3:0] info_nib = (info == codec_pkg::INFO_SINGLE) ? `INFO_SINGLE :
                        (info == codec_pkg::INFO_DOUBLE) ? `INFO_DOUBLE :
                        (info == codec_pkg::INFO_TAP) ? `INFO_TAP : `INFO_STAT;
  logic [7:0] info_b;
  always_comb begin
    info_b = {4'h0, info_nib};
    info_b[`GS_BIT] = ev_gscan_i;
    info_b[`SCAN_LAST_ENTRY_FLAG_BIT] = ev_gscan_i && ev_scan_last_entry_flag_i;
  end
  wire [7:0] cause_b = cause_en ? {5'h00, ev_cause_i} : 8'h00;
  wire [11:0] year_off = ev_year_i - `YEAR_BASE;

  logic [7:0][15:0] words_d;
  always_comb begin
    words_d[0] = {type_b, off_b};
    words_d[1] = reg_addr[15:0];
    words_d[2] = {cause_b, info_b};
    words_d[3] = ev_value_i;
    words_d[4] = ev_ms_i;
    words_d[5] = {3'h0, ev_hour_i, 2'h0, ev_min_i};
    words_d[6] = {4'h0, ev_month_i, 3'h0, ev_day_i};
    words_d[7] = {time_q, year_off[7:0]};
  end

  // packing writes one word a cycle into the free slot
  wire pack_done = !pack_idle && (idx_q == `EV_LAST_WORD);
  wire release_ok = wr_release && (cnt_q != 3'h0);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_q <= codec_pkg::PACK_IDLE;
      idx_q <= 3'h0;
      wr_slot_q <= 2'h0;
      words_q <= '0;
    end else begin
      case (state_q)
        codec_pkg::PACK_IDLE: begin
          idx_q <= 3'h0;
          if (start_pack) begin
            words_q <= words_d;
            state_q <= codec_pkg::PACK_WRITE;
          end
        end
        codec_pkg::PACK_WRITE: begin
          idx_q <= idx_q + 3'h1;
          if (pack_done) begin
            state_q <= codec_pkg::PACK_IDLE;
            wr_slot_q <= wr_slot_q + 2'h1;
          end
        end
        default: state_q <= codec_pkg::PACK_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 3'h0;
      rd_slot_q <= 2'h0;
    end else begin
      case ({pack_done, release_ok})
        2'b10: cnt_q <= cnt_q + 3'h1;
        2'b01: cnt_q <= cnt_q - 3'h1;
        default: cnt_q <= cnt_q;
      endcase
      if (release_ok) rd_slot_q <= rd_slot_q + 2'h1;
    end
  end
  assign ev_count_o = cnt_q;

  logic [15:0] ram_q;
  event_slot_ram u_ram (
    .sys_clk_i(sys_clk_i),
    .we_i(!pack_idle),
    .waddr_i({wr_slot_q, idx_q}),
    .wdata_i(words_q[idx_q]),
    .raddr_i({rd_slot_q, addr_i[2:0]}),
    .rdata_o(ram_q)
  );

  // read decode
  always_comb begin
    rd_d = 16'h0000;
    if (addr_i == `A_MEAS_IN) begin
      rd_d = meas_q;
    end else if (addr_i == `A_MEAS_OUT) begin
      rd_d = meas_out_q;
    end else if (addr_i == `A_METER_HI) begin
      rd_d = count_q[31:16];
    end else if (addr_i == `A_METER_LO) begin
      rd_d = snap_q;
    end else if (addr_i == `A_METER_STAT) begin
      rd_d = {15'h0000, meter_stat};
    end else if (addr_i == `A_TAP_CMD) begin
      rd_d = {14'h0000, tap_res_q};
    end else if (addr_i == `A_TAP_POS) begin
      rd_d = tap_q;
    end else if (addr_i == `A_TIME_STAT) begin
      rd_d = {8'h00, time_q};
    end else if (addr_i == `A_EV_CFG) begin
      rd_d = cfg_q;
    end else if (addr_i == `A_EV_STAT) begin
      rd_d = {13'h0000, cnt_q};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_q <= 16'h0000;
      win_q <= 1'b0;
      empty_q <= 1'b1;
      idx0_q <= 1'b0;
    end else begin
      rd_q <= rd_i ? rd_d : 16'h0000;
      win_q <= rd_i && win_hit;
      empty_q <= (cnt_q == 3'h0);
      idx0_q <= (addr_i[2:0] == 3'h0);
    end
  end

  wire [15:0] win_word = !empty_q ? ram_q : (idx0_q ? {`TYPE_EMPTY, 8'h00} : 16'h0000);
  assign rdata_o = win_q ? win_word : rd_q;

  sequence s_take;
    pack_idle && start_pack;
  endsequence
  sequence s_write8;
    (state_q == codec_pkg::PACK_WRITE)[*8] ##1 (state_q == codec_pkg::PACK_IDLE);
  endsequence

  AST_MEAS_INVALID: assert property (meas_invalid_i |=> meas_q == 16'h8000)
    else $error("invalid measured value not coded as 8000");
  AST_MEAS_SIGN: assert property (!meas_invalid_i |=> meas_q[15] == $past(meas_raw_i[15]))
    else $error("measured status bit differs from sign");
  AST_METER_WRAP: assert property (meter_inc_i && count_q == 32'h7fffffff |=> count_q == 32'h0)
    else $error("metered count did not wrap to zero");
  AST_TAP_LOWER: assert property (wr_tap && wdata_i == 16'h0001
                                  |=> tap_lower_o && !tap_raise_o && !tap_reject_o)
    else $error("lower command not issued");
  // zero is as illegal as anything above raise
  AST_TAP_REJECT: assert property (wr_tap && wdata_i != 16'h0001 && wdata_i != 16'h0002
                                   |=> tap_reject_o && !tap_lower_o && !tap_raise_o)
    else $error("bad tap command not rejected");
  AST_TAP_UNROUTED: assert property (tap_unassigned_i |=> tap_q == 16'h8000)
    else $error("unassigned tap position wrong");
  AST_TAP_RANGE: assert property (!tap_q[15] |-> tap_q[15:6] == 10'h0 && tap_q[5:0] != 6'h0)
    else $error("tap position out of range");
  AST_TIME_STAT: assert property (##1 time_q == $past({1'b0, time_invalid_i, time_fail_i, dst_i, 4'h0}))
    else $error("time status byte wrong");
  AST_PACK_EIGHT: assert property (s_take |=> s_write8)
    else $error("entry not packed in eight words");
  AST_ADDR_MINUS1: assert property (s_take |=> words_q[1] == $past(ev_reg_num_i[15:0]) - 16'h0001)
    else $error("event address not number minus one");
  AST_OFFSET_LOG2: assert property ((s_take and (is_hold && ev_mask_i == 16'h0010))
                                    |=> words_q[0][7:0] == 8'h04)
    else $error("bit offset not log2 of mask");
  AST_CAUSE_OFF: assert property ((s_take and !cause_en) |=> words_q[2][15:8] == 8'h00)
    else $error("cause byte not zero with causes off");
  AST_EMPTY_SLOT: assert property (rd_i && win_hit && addr_i[2:0] == 3'h0 && cnt_q == 3'h0
                                   |=> rdata_o[15:8] == 8'hff)
    else $error("empty slot type byte not ff");
endmodule
`default_nettype wire

// ---- test/reg_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module reg_master_model (
  // register port, master side
  input wire logic sys_clk_i,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  // read return
  input wire logic [15:0] rdata_i
);
  initial begin
    addr_o = 8'hff;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // released lines show the inverse so a stale value never passes
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    // data stand only in this cycle
    @(negedge sys_clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- test/register_value_codec_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module register_value_codec_tb;
  logic sys_clk_i, nrst_i, wr_i, rd_i;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, meas_raw_i, meas_out_o, ev_mask_i, ev_value_i, ev_ms_i, rv;
  logic meas_invalid_i, meter_inc_i, meter_update_i, meter_err_i;
  logic tap_lower_o, tap_raise_o, tap_reject_o, tap_invalid_i, tap_unassigned_i;
  logic [5:0] tap_pos_i, ev_min_i;
  logic dst_i, time_fail_i, time_invalid_i, ev_valid_i, ev_ready_o;
  logic ev_gscan_i, ev_scan_last_entry_flag_i;
  logic [1:0] ev_reg_kind_i, ev_info_kind_i;
  logic [16:0] ev_reg_num_i;
  logic [2:0] ev_cause_i, ev_count_o;
  logic [4:0] ev_hour_i, ev_day_i;
  logic [3:0] ev_month_i;
  logic [11:0] ev_year_i;
  logic [15:0] fx [5];
  logic [15:0] mv [3];
  logic [15:0] tc [4];
  logic [15:0] te [4];
  logic [5:0] tp [4];
  int miscompares, checks_done;

  register_value_codec i_register_value_codec (.*);
  reg_master_model i_reg_master_model (.sys_clk_i(sys_clk_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, want, got);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] want, input string n);
    i_reg_master_model.rd_reg(a, rv);
    chk(n, rv, want);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    i_reg_master_model.wr_reg(a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic cnt(input logic [15:0] want);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("ev_count", {13'h0000, ev_count_o}, want);
  endtask
  task automatic ev(input logic [1:0] k, input logic [15:0] m, input logic [16:0] num,
    input logic [2:0] c, input logic [1:0] inf, input logic g, input logic l);
    int t;
    @(posedge sys_clk_i);
    ev_reg_kind_i <= k;
    ev_mask_i <= m;
    ev_reg_num_i <= num;
    ev_cause_i <= c;
    ev_info_kind_i <= inf;
    ev_gscan_i <= g;
    ev_scan_last_entry_flag_i <= l;
    ev_valid_i <= 1'b1;
    t = 0;
    do begin
      @(negedge sys_clk_i);
      t++;
    end while (ev_ready_o !== 1'b1 && t < 40);
    @(posedge sys_clk_i);
    ev_valid_i <= 1'b0;
    // packing takes eight words plus one
    cyc(10);
  endtask
  task automatic win(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2, input logic hold);
    i_reg_master_model.rd_reg(8'h10, rv);
    if (hold) begin
      chk("type_offset", rv, w0);
    end else begin
      chk("type", {8'h00, rv[15:8]}, {8'h00, w0[15:8]});
    end
    rdc(8'h11, w1, "address");
    rdc(8'h12, w2, "cause_info");
    for (int i = 0; i < 5; i++) begin
      rdc(8'h13 + 8'(i), fx[i], "value_stamp");
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    stop_test;
  end

  initial begin
    nrst_i = 1'b0;
    {meas_raw_i, meas_invalid_i, meter_inc_i, meter_update_i, meter_err_i, tap_pos_i, tap_invalid_i,
      tap_unassigned_i, dst_i, time_fail_i, time_invalid_i, ev_valid_i, ev_reg_kind_i, ev_mask_i,
      ev_reg_num_i, ev_cause_i, ev_info_kind_i, ev_gscan_i, ev_scan_last_entry_flag_i} = '0;
    ev_value_i = 16'h1234;
    ev_ms_i = 16'hea5f;
    ev_hour_i = 5'h17;
    ev_min_i = 6'h3b;
    ev_month_i = 4'hc;
    ev_day_i = 5'h1f;
    ev_year_i = 12'h7e8;
    fx = '{16'h1234, 16'hea5f, 16'h173b, 16'h0c1f, 16'h107c};
    mv = '{16'h8001, 16'h7fff, 16'h0000};
    tc = '{16'h0001, 16'h0002, 16'h0003, 16'h0000};
    tp = '{6'h01, 6'h3e, 6'h05, 6'h05};
    te = '{16'h0001, 16'h003e, 16'h003f, 16'h8000};
    cyc(2);
    nrst_i <= 1'b1;
    rdc(8'h08, 16'h0001, "cfg_reset");
    rdc(8'h09, 16'h0000, "stat_reset");
    rdc(8'h01, 16'h0000, "meas_out_reset");
    rdc(8'h04, 16'h0001, "meter_stat_reset");
    rdc(8'h10, 16'hff00, "empty_slot");
    rdc(8'h20, 16'h0000, "unmapped");
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i);
      meas_raw_i <= mv[i];
      meas_invalid_i <= (i == 2);
      cyc(2);
      rdc(8'h00, i == 2 ? 16'h8000 : mv[i], "meas_in");
    end
    wrr(8'h01, 16'h8000);
    @(negedge sys_clk_i);
    chk("meas_out", meas_out_o, 16'h8000);
    rdc(8'h01, 16'h8000, "meas_out_rd");
    // counter status must survive exactly one update
    @(posedge sys_clk_i);
    meter_inc_i <= 1'b1;
    meter_update_i <= 1'b1;
    cyc(1);
    meter_update_i <= 1'b0;
    cyc(4);
    meter_inc_i <= 1'b0;
    cyc(2);
    rdc(8'h04, 16'h0001, "meter_stat_one");
    rdc(8'h02, 16'h0000, "meter_hi");
    rdc(8'h03, 16'h0005, "meter_lo");
    @(posedge sys_clk_i);
    meter_update_i <= 1'b1;
    cyc(1);
    meter_update_i <= 1'b0;
    cyc(2);
    rdc(8'h04, 16'h0000, "meter_stat_two");
    @(posedge sys_clk_i);
    meter_err_i <= 1'b1;
    cyc(2);
    rdc(8'h04, 16'h0001, "meter_stat_err");
    @(posedge sys_clk_i);
    meter_err_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wrr(8'h05, tc[i]);
      @(negedge sys_clk_i);
      chk("tap_pulse", {13'h0000, tap_reject_o, tap_raise_o, tap_lower_o}, {13'h0000, i > 1, i == 1, i == 0});
      @(negedge sys_clk_i);
      chk("tap_idle", {13'h0000, tap_reject_o, tap_raise_o, tap_lower_o}, 16'h0000);
      rdc(8'h05, i > 1 ? 16'h0002 : 16'h0001, "tap_stat");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      tap_pos_i <= tp[i];
      tap_invalid_i <= (i == 2);
      tap_unassigned_i <= (i == 3);
      cyc(2);
      rdc(8'h06, te[i], "tap_pos");
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      {time_invalid_i, time_fail_i, dst_i} <= i[2:0];
      cyc(2);
      rdc(8'h07, {9'h000, i[2:0], 4'h0}, "time_stat");
    end
    @(posedge sys_clk_i);
    {time_invalid_i, time_fail_i, dst_i} <= 3'h1;
    for (int i = 0; i < 4; i++) begin
      ev(2'(i < 2 ? i : 2), 16'h0001 << (i * 5), i == 3 ? 17'h10000 : 17'h00081, 3'(2 * i), 2'(i), i[0], i == 3);
    end
    cnt(16'h0004);
    chk("ready_full", {15'h0000, ev_ready_o}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      win({i < 2 ? 8'(i) : 8'h04, 8'(i * 5)}, i == 3 ? 16'hffff : 16'h0080,
        {5'h00, 3'(2 * i), i[0], i == 3, 2'h0, 4'(i + 1)}, i > 1);
      wrr(8'h09, 16'h0001);
      cnt(16'(3 - i));
    end
    rdc(8'h10, 16'hff00, "empty_again");
    wrr(8'h08, 16'h0000);
    ev(2'h2, 16'h0010, 17'h00081, 3'h3, 2'h0, 1'b0, 1'b0);
    ev(2'h2, 16'h0010, 17'h00081, 3'h5, 2'h0, 1'b0, 1'b0);
    cnt(16'h0000);
    ev(2'h2, 16'h0010, 17'h00081, 3'h1, 2'h0, 1'b0, 1'b0);
    cnt(16'h0001);
    win(16'h0404, 16'h0080, 16'h0001, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire
